// *** pkg/adcsc_pkg.sv ***
// Constants, field positions and types shared by the ADC setup block.
// Assumes a serial link clocked by the host and a 20 MHz core clock.
// Functional notes
// - Byte 01xxxxxx is a setup command
// - Bits 5:4 choose clock mode behaviour
// - Mode 01 pin acquisition; mode 11 serial clock
// - Modes 00/01 pin starts; 10/11 analog input
// - Reference 00 internal, sleeps, needs wake delay
// - Reference 10 internal, always on; code powers it only after the first conversion wakes the part
// - Codes 01/11 external; 11 makes negative ref
// - Select 00/01 means no data byte
// - Select 10 stores next byte as unipolar
// - Select 11 stores next byte as bipolar
// - Unipolar bit 7 pair 0/1 down
// - Bipolar bit 7 pair 0/1 down
// - Reset bit one clears FIFO only
// - Reset bit zero restores all defaults
// - Power up with everything shut down
// - Registers zero, setup resets to clock mode 10
// - Temperature is high minus low bias result
// - Subtract Kelvin offset, eighth degree steps
// - Output word is four zeros, twelve bits
// - Sample input rising, change output falling
// - Start source depends on clock mode
// - Unipolar straight binary, bipolar two's complement
// - Pair in both registers counts as unipolar
// - No data announced: next byte is command
package adcsc_pkg;
   // ========================================
   // Command byte layout
   localparam int CMD_CONV_BIT = 7;
   localparam int CMD_SETUP_BIT = 6;
   localparam int CMD_AVG_BIT = 5;
   localparam int CMD_RESET_BIT = 4;
   localparam int RESET_SEL_BIT = 3;
   localparam int CKSEL_HI = 5;
   localparam int CKSEL_LO = 4;
   localparam int REFSEL_HI = 3;
   localparam int REFSEL_LO = 2;
   localparam int DIFF_HI = 1;
   localparam int DIFF_LO = 0;
   // ========================================
   // Reset values
   localparam logic [7:0] SETUP_RST = 8'h20;
   localparam logic [7:0] PAIR_RST = 8'h00;
   localparam logic [7:0] AVG_RST = 8'h00;
   // ========================================
   // Field codes
   localparam logic [1:0] CK_PIN_INT = 2'h0;
   localparam logic [1:0] CK_PIN_EXT = 2'h1;
   localparam logic [1:0] CK_SER_INT = 2'h2;
   localparam logic [1:0] CK_SER_EXT = 2'h3;
   localparam logic [1:0] REF_INT_SLEEP = 2'h0;
   localparam logic [1:0] REF_EXT_SE = 2'h1;
   localparam logic [1:0] REF_INT_ON = 2'h2;
   localparam logic [1:0] REF_EXT_DIFF = 2'h3;
   localparam logic [1:0] DIFF_UNI = 2'h2;
   localparam logic [1:0] DIFF_BI = 2'h3;
   // ========================================
   // Timing and data format
   localparam int SER_CLK_MAX_KHZ = 4800;
   localparam int RESULT_BITS = 12;
   localparam int LEAD_ZEROS = 4;
   localparam int WORD_BITS = 16;
   // Kelvin offset in eighth-degree steps (273.0 K times 8)
   localparam logic [12:0] KELVIN_OFS = 13'h0888;
   localparam int CORE_CLK_NS = 50;
   localparam int PIN_LOW_NS = 40;
   localparam int PIN_LOW_CYC = (PIN_LOW_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

   typedef enum logic [1:0] {ADCSC_CMD, ADCSC_UNI, ADCSC_BI} adcsc_rx_t;
endpackage

// *** pkg/adcsc_cfg_if.sv ***
// Configuration bundle passed from the decoder to the mode logic.
// Assumes both ends live in the core clock domain.
`timescale 1ns/10ps
interface adcsc_cfg_if;
   logic [7:0] setup;
   logic [7:0] uni;
   logic [7:0] bi;
   logic fifo_clr;
   logic conv_req;
   modport src (output setup, output uni, output bi, output fifo_clr,
      output conv_req);
   modport dst (input setup, input uni, input bi, input fifo_clr,
      input conv_req);
endinterface

// *** logic/adcsc_serial_rx.sv ***
// Serial receiver on the link clock: shifts input bits into bytes.
// Assumes chip select low frames each transfer; clock stops outside frames.
`timescale 1ns/10ps
module adcsc_serial_rx
   import adcsc_pkg::*;
(
   // Reset from the core side, released while the link clock stands still
   input wire logic resetn,
   // Link side
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdin,
   // Byte out, toggle event
   output logic [7:0] byte_r,
   output logic byte_tgl_r
);
   logic [2:0] cnt_r;
   logic [6:0] sh_r;

   // ========================================
   // Shift on rising edge; frame start via async chip select
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_r <= 3'h0;
         sh_r <= 7'h00;
      end else begin
         sh_r <= {sh_r[5:0], sdin};
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // Completed byte held stable; toggle tells the core a byte landed.
   // Toggle must start at the core synchroniser's reset level, or the
   // first byte after reset would be seen twice or not at all.
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         byte_r <= 8'h00;
         byte_tgl_r <= 1'b0;
      end else if (!cs_n && cnt_r == 3'h7) begin
         byte_r <= {sh_r, sdin};
         byte_tgl_r <= ~byte_tgl_r;
      end
   end
endmodule

// *** logic/adcsc_serial_tx.sv ***
// Serial transmitter on the link clock: shifts a 16-bit result word out.
// Assumes the word is stable while chip select is low.
`timescale 1ns/10ps
module adcsc_serial_tx
   import adcsc_pkg::*;
(
   // Link side
   input wire logic sclk,
   input wire logic cs_n,
   output logic sdout,
   // Word to send, held in the core domain
   input wire logic [15:0] word
);
   logic [3:0] idx_r;

   // Falling-edge update so the host samples on the rising edge
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n)
         idx_r <= 4'hF;
      else
         idx_r <= idx_r - 4'h1;
   end

   // Output bit from a flip-flop, MSB first
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n)
         sdout <= 1'b0;
      else
         sdout <= word[idx_r - 4'h1];
   end
endmodule

// *** logic/adcsc_top.sv ***
// Setup, pair and reset decoding for the 12-bit serial converter.
// Assumes bytes arrive from the link receiver; core runs at 20 MHz.
`timescale 1ns/10ps
module adcsc_top
   import adcsc_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdin,
   output logic sdout,
   // Shared start pin
   input wire logic convert_start_pin,
   // Conversion results and temperature inputs
   input wire logic [11:0] result,
   input wire logic result_is_temp,
   input wire logic [11:0] temp_hi_bias,
   input wire logic [11:0] temp_lo_bias,
   // Mode outputs
   output logic int_conv_clk,
   output logic ext_acq_timing,
   output logic ser_clk_conv,
   output logic start_pin_active,
   output logic top_analog_input,
   output logic ref_internal,
   output logic ref_powered,
   output logic ref_wake_needed,
   output logic ref_neg_pin,
   output logic [7:0] unipolar_pair_bit,
   output logic [7:0] bipolar_pair_bit,
   output logic [7:0] pair_bipolar_eff,
   output logic all_shutdown,
   output logic fifo_clear,
   output logic conv_start,
   output logic [12:0] temp_code
);
   adcsc_cfg_if cfg();
   logic [7:0] rx_byte;
   logic rx_tgl;
   logic [2:0] tgl_sync_r;
   logic [2:0] pin_sync_r;
   logic pin_state_r;
   logic [1:0] pin_low_cnt_r;
   adcsc_rx_t rx_st_r, rx_st_nxt;
   logic [7:0] setup_r, uni_r, bi_r, avg_r;
   logic clr_r, full_r, conv_r, pin_start_r, woken_r;
   logic [15:0] word_r;
   logic [12:0] temp_r;

   // ========================================
   // Link-domain receiver and transmitter
   adcsc_serial_rx u_rx (
      .resetn(resetn),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdin(sdin),
      .byte_r(rx_byte),
      .byte_tgl_r(rx_tgl)
   );

   adcsc_serial_tx u_tx (
      .sclk(sclk),
      .cs_n(cs_n),
      .sdout(sdout),
      .word(word_r)
   );

   // ========================================
   // Byte event crossing: three stages, edge when the last two stages differ
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         tgl_sync_r <= 3'h0;
      else
         tgl_sync_r <= {tgl_sync_r[1:0], rx_tgl};
   end
   wire byte_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
   // Byte is stable for a whole byte time when the event lands
   wire [7:0] cmd = rx_byte;

   // ========================================
   // Command decode by leading one among the upper four bits
   function automatic logic [3:0] lead_one(input logic [7:0] b);
      lead_one = b[7] ? 4'h8 : b[6] ? 4'h4 : b[5] ? 4'h2 :
         b[4] ? 4'h1 : 4'h0;
   endfunction
   wire [3:0] tgt = lead_one(cmd);
   wire is_conv = tgt[3];
   wire is_setup = tgt[2];
   wire is_avg = tgt[1];
   wire is_reset = tgt[0];
   wire cmd_evt = byte_evt && rx_st_r == ADCSC_CMD;
   wire diff_sel = cmd[DIFF_HI];

   // ========================================
   // Receive state: does the next byte belong to a pair register
   always_comb begin
      rx_st_nxt = rx_st_r;
      if (byte_evt) begin
         case (rx_st_r)
            ADCSC_CMD:
               if (is_setup && diff_sel) begin
                  rx_st_nxt = cmd[DIFF_LO] ? ADCSC_BI : ADCSC_UNI;
               end else begin
                  rx_st_nxt = ADCSC_CMD;
               end
            ADCSC_UNI: rx_st_nxt = ADCSC_CMD;
            ADCSC_BI: rx_st_nxt = ADCSC_CMD;
            default: rx_st_nxt = ADCSC_CMD;
         endcase
      end
   end

   wire full_rst = cmd_evt && is_reset && !cmd[RESET_SEL_BIT];
   wire fifo_rst = cmd_evt && is_reset && cmd[RESET_SEL_BIT];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         rx_st_r <= ADCSC_CMD;
      else if (full_rst)
         rx_st_r <= ADCSC_CMD;
      else
         rx_st_r <= rx_st_nxt;
   end

   // ========================================
   // Configuration registers; full reset restores power-up values
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         setup_r <= SETUP_RST;
         uni_r <= PAIR_RST;
         bi_r <= PAIR_RST;
         avg_r <= AVG_RST;
      end else if (full_rst) begin
         setup_r <= SETUP_RST;
         uni_r <= PAIR_RST;
         bi_r <= PAIR_RST;
         avg_r <= AVG_RST;
      end else if (byte_evt) begin
         if (cmd_evt && is_setup)
            setup_r <= cmd;
         if (cmd_evt && is_avg)
            avg_r <= cmd;
         if (rx_st_r == ADCSC_UNI)
            uni_r <= cmd;
         if (rx_st_r == ADCSC_BI)
            bi_r <= cmd;
      end
   end

   // ========================================
   // One-cycle strobes for FIFO clear and full reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clr_r <= 1'b0;
         full_r <= 1'b0;
      end else begin
         clr_r <= fifo_rst | full_rst;
         full_r <= full_rst;
      end
   end

   // ========================================
   // Start pin: three stages, state moves when the last two agree
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         pin_sync_r <= 3'h7;
      else
         pin_sync_r <= {pin_sync_r[1:0], convert_start_pin};
   end
   wire pin_agree = pin_sync_r[2] == pin_sync_r[1];

   // Low time counted so a glitch shorter than the minimum is ignored
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_state_r <= 1'b1;
         pin_low_cnt_r <= 2'h0;
      end else begin
         if (pin_agree)
            pin_state_r <= pin_sync_r[2];
         if (pin_state_r)
            pin_low_cnt_r <= 2'h0;
         else if (pin_low_cnt_r != 2'h3)
            pin_low_cnt_r <= pin_low_cnt_r + 2'h1;
      end
   end
   wire pin_rise = pin_agree && pin_sync_r[2] && !pin_state_r &&
      pin_low_cnt_r >= 2'(PIN_LOW_CYC);

   // ========================================
   // Clock mode decoding
   wire [1:0] ck_mode = setup_r[CKSEL_HI:CKSEL_LO];
   wire [1:0] ref_mode = setup_r[REFSEL_HI:REFSEL_LO];
   wire pin_mode = !ck_mode[1];

   assign int_conv_clk = ck_mode != CK_SER_EXT;
   assign ext_acq_timing = ck_mode == CK_PIN_EXT || ck_mode == CK_SER_EXT;
   assign ser_clk_conv = ck_mode == CK_SER_EXT;
   assign start_pin_active = pin_mode;
   assign top_analog_input = !pin_mode;

   // Conversion start: pin edge in pin modes, conversion byte otherwise
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         conv_r <= 1'b0;
         pin_start_r <= 1'b0;
      end else begin
         conv_r <= pin_mode ? pin_rise : (cmd_evt && is_conv);
         pin_start_r <= pin_rise;
      end
   end
   assign conv_start = conv_r;

   // ========================================
   // Reference control; stays shut down until first conversion
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         woken_r <= 1'b0;
      else if (full_r)
         woken_r <= 1'b0;
      else if (conv_r)
         woken_r <= 1'b1;
   end
   assign all_shutdown = !woken_r;
   assign ref_internal = !ref_mode[0];
   // Always-on reference only after the first wake, to honour shutdown
   assign ref_powered = woken_r && ref_mode == REF_INT_ON;
   assign ref_wake_needed = ref_mode == REF_INT_SLEEP;
   assign ref_neg_pin = ref_mode == REF_EXT_DIFF;

   // ========================================
   // Pair enables; unipolar wins when both are set
   assign unipolar_pair_bit = uni_r;
   assign bipolar_pair_bit = bi_r;
   assign pair_bipolar_eff = bi_r & ~uni_r;

   // ========================================
   // Temperature arithmetic in eighth-degree steps
   function automatic logic [12:0] temp_calc(input logic [11:0] hi,
      input logic [11:0] lo);
      logic [12:0] absk;
      absk = {1'b0, hi} - {1'b0, lo};
      temp_calc = absk - KELVIN_OFS;
   endfunction

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         temp_r <= 13'h0000;
      else
         temp_r <= temp_calc(temp_hi_bias, temp_lo_bias);
   end
   assign temp_code = temp_r;

   // ========================================
   // Output word: four zeros then twelve result bits. Result coding
   // (binary or two's complement) is passed through as converted.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         word_r <= 16'h0000;
      else if (cs_n)
         word_r <= {4'h0, result_is_temp ? temp_r[11:0] : result};
   end

   // ========================================
   // Interface bundle for downstream mode logic
   assign cfg.setup = setup_r;
   assign cfg.uni = uni_r;
   assign cfg.bi = bi_r;
   assign cfg.fifo_clr = clr_r;
   assign cfg.conv_req = conv_r;
   assign fifo_clear = cfg.fifo_clr;
endmodule

// *** verif/adcsc_asserts.sv ***
// Checker for adcsc_top: mode decode, pulses and temperature arithmetic.
// Assumes only the top ports are visible; everything is core clock domain.
`timescale 1ns/10ps
module adcsc_asserts
   import adcsc_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Temperature inputs
   input wire logic [11:0] temp_hi_bias,
   input wire logic [11:0] temp_lo_bias,
   // Decoded outputs
   input wire logic int_conv_clk,
   input wire logic ext_acq_timing,
   input wire logic ser_clk_conv,
   input wire logic start_pin_active,
   input wire logic top_analog_input,
   input wire logic ref_internal,
   input wire logic ref_powered,
   input wire logic ref_wake_needed,
   input wire logic ref_neg_pin,
   input wire logic [7:0] unipolar_pair_bit,
   input wire logic [7:0] bipolar_pair_bit,
   input wire logic [7:0] pair_bipolar_eff,
   input wire logic all_shutdown,
   input wire logic fifo_clear,
   input wire logic conv_start,
   input wire logic [12:0] temp_code
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // =======================================
   // Expected temperature, 13 bits wrap like the result register
   logic [12:0] t_exp;
   assign t_exp = {1'b0, temp_hi_bias} - {1'b0, temp_lo_bias} - KELVIN_OFS;
   // =======================================
   // Pin role and clock source decode
   a_pin_role_split: assert property (
      start_pin_active != top_analog_input)
      else $error("start pin role and analog role overlap");
   // External timing comes from the start pin or from the serial clock
   a_ext_acq_mode: assert property (
      ext_acq_timing |-> (start_pin_active && int_conv_clk) ||
      (ser_clk_conv && top_analog_input))
      else $error("external acquisition without its timing source");
   a_ser_clk_mode: assert property (
      ser_clk_conv |-> top_analog_input && !int_conv_clk)
      else $error("serial clock conversion with wrong pin role");
   // =======================================
   // Reference decode
   a_wake_internal: assert property (
      ref_wake_needed |-> ref_internal && !ref_powered && !ref_neg_pin)
      else $error("wake delay flagged on a non sleeping reference");
   a_ref_always_on: assert property (
      ref_powered |-> ref_internal && !ref_wake_needed)
      else $error("powered reference still needs wake delay");
   a_neg_ref_ext: assert property (
      ref_neg_pin |-> !ref_internal)
      else $error("negative reference pin with internal reference");
   // =======================================
   // Pairs, pulses and temperature
   a_uni_wins: assert property (
      pair_bipolar_eff == (bipolar_pair_bit & ~unipolar_pair_bit))
      else $error("pair in both registers not treated as unipolar");
   a_fifo_one_pulse: assert property (
      fifo_clear |=> !fifo_clear)
      else $error("fifo clear longer than one cycle");
   a_conv_one_pulse: assert property (
      conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   a_temp_calc: assert property (
      $past(resetn) |-> temp_code == $past(t_exp))
      else $error("temperature code differs from bias difference");
   a_shutdown_exit: assert property (
      $fell(all_shutdown) |-> conv_start || $past(conv_start))
      else $error("shutdown left without a conversion start");
endmodule

bind adcsc_top adcsc_asserts adcsc_asserts_inst (.*);

// *** verif/adcsc_host_model.sv ***
// Host serial master: frames bytes MSB first and collects the reply.
// Assumes sclk idles low and stands still between frames.
`timescale 1ns/10ps
module adcsc_host_model (
   // Link pins
   output logic sclk,
   output logic cs_n,
   output logic sdin,
   input wire logic sdout
);
   localparam real HALF = 62.5;
   logic last;
   // Idle link after power up
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdin = 1'b1;
      last = 1'b0;
   end
   // One frame of n bits; stretch slows each low phase like a slow host
   task automatic frame(input logic [15:0] tx, input int n,
      input int stretch, output logic [15:0] rx);
      rx = 16'h0000;
      #7;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdin = tx[i];
         last = tx[i];
         #(HALF + stretch);
         sclk = 1'b1;
         rx = {rx[14:0], sdout};
         #(HALF);
         sclk = 1'b0;
      end
      #(HALF);
      cs_n = 1'b1;
      // Released line must not show the last bit
      sdin = ~last;
      #(HALF);
   endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for adcsc_top driven through a host link model.
// Assumes a 20 MHz core clock; the model makes the 125 ns link clock.
`timescale 1ns/10ps
module tb_top;
   import adcsc_pkg::*;
   logic core_clk, resetn, sclk, cs_n, sdin, sdout, convert_start_pin;
   logic [11:0] result, temp_hi_bias, temp_lo_bias;
   logic result_is_temp, int_conv_clk, ext_acq_timing, ser_clk_conv;
   logic start_pin_active, top_analog_input, ref_internal, ref_powered;
   logic ref_wake_needed, ref_neg_pin, all_shutdown, fifo_clear;
   logic conv_start;
   logic [7:0] unipolar_pair_bit, bipolar_pair_bit, pair_bipolar_eff;
   logic [12:0] temp_code;
   logic [15:0] rx;
   int mismatches = 0;
   int n_tests = 0;
   int n_fifo = 0;
   int n_conv = 0;
   wire logic [7:0] modes = {int_conv_clk, ext_acq_timing, ser_clk_conv,
      start_pin_active, top_analog_input, ref_internal, ref_wake_needed,
      ref_neg_pin};
   adcsc_top adcsc_top_inst (.*);
   adcsc_host_model adcsc_host_model_inst (.sclk, .cs_n, .sdin, .sdout);
   // =======================================
   // Clock and pulse counters
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (fifo_clear === 1'b1) n_fifo++;
      if (conv_start === 1'b1) n_conv++;
   end
   // =======================================
   // Shared helpers
   task automatic chk(input string nm, input logic [15:0] e, s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Frame then let the core take the byte
   task automatic send(input logic [15:0] v, input int n, input int st);
      adcsc_host_model_inst.frame(v, n, st, rx);
      repeat (6) @(negedge core_clk);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // =======================================
   // Scenarios
   task automatic t_defaults;
      chk("modes", 16'h008E, modes);
      chk("pairs", 16'h0000, {unipolar_pair_bit, bipolar_pair_bit});
      chk("sleep", 16'h0001, {ref_powered, all_shutdown});
      $display("defaults done");
   endtask
   task automatic t_modes;
      logic [7:0] e;
      send({8'h42, 8'h3C}, 16, 0);
      for (int ck = 0; ck < 4; ck++) begin
         for (int rf = 0; rf < 4; rf++) begin
            send({10'h001, ck[1:0], rf[1:0], 1'b0, rf[0]}, 8, ck * 40);
            e = {ck != 3, ck % 2 == 1, ck == 3, ck < 2, ck > 1, rf[0] == 0,
               rf == 0, rf == 3};
            chk("modes", {8'h00, e}, modes);
            chk("uni kept", 16'h003C, unipolar_pair_bit);
         end
      end
      $display("modes done");
   endtask
   task automatic t_pairs;
      int f;
      send({8'h42, 8'hA5}, 16, 0);
      chk("uni", 16'h00A5, unipolar_pair_bit);
      send({8'h43, 8'h5A}, 16, 0);
      chk("bi", 16'h005A, bipolar_pair_bit);
      send(8'h43, 8, 0);
      send(8'hFF, 8, 0);
      chk("eff", 16'h005A, pair_bipolar_eff);
      f = n_fifo;
      send(8'h41, 8, 0);
      send(8'h1F, 8, 0);
      chk("fifo", 16'(f + 1), 16'(n_fifo));
      chk("uni", 16'h00A5, unipolar_pair_bit);
      chk("modes", 16'h0096, modes);
      f = n_fifo;
      send(8'h17, 8, 0);
      chk("fifo", 16'(f + 1), 16'(n_fifo));
      chk("modes", 16'h008E, modes);
      chk("pairs", 16'h0000, {unipolar_pair_bit, bipolar_pair_bit});
      $display("pairs done");
   endtask
   task automatic t_conv;
      int c;
      c = n_conv;
      send(8'h81, 8, 0);
      chk("conv", 16'(c + 1), 16'(n_conv));
      chk("awake", 16'h0000, all_shutdown);
      send(8'h68, 8, 0);
      chk("powered", 16'h0001, ref_powered);
      send(8'h41, 8, 0);
      send(8'h81, 8, 0);
      chk("conv", 16'(c + 1), 16'(n_conv));
      convert_start_pin = 1'b0;
      repeat (2) @(negedge core_clk);
      convert_start_pin = 1'b1;
      // Three sync stages, agreement, strobe register, then the counter
      repeat (7) @(negedge core_clk);
      chk("conv", 16'(c + 2), 16'(n_conv));
      $display("conversion done");
   endtask
   task automatic t_temp_word;
      temp_hi_bias = 12'h900;
      temp_lo_bias = 12'h010;
      result = 12'hABC;
      repeat (3) @(negedge core_clk);
      chk("temp", 16'h0068, {3'b000, temp_code});
      temp_hi_bias = 12'h100;
      temp_lo_bias = 12'h000;
      repeat (3) @(negedge core_clk);
      chk("temp", 16'h1878, {3'b000, temp_code});
      adcsc_host_model_inst.frame(16'h0000, 16, 0, rx);
      chk("word", 16'h0ABC, rx);
      result_is_temp = 1'b1;
      repeat (2) @(negedge core_clk);
      adcsc_host_model_inst.frame(16'h0000, 16, 0, rx);
      chk("temp word", 16'h0878, rx);
      $display("temperature and word done");
   endtask
   // =======================================
   // Main sequence and watchdog
   initial begin
      resetn = 1'b0;
      convert_start_pin = 1'b1;
      result = 12'h000;
      result_is_temp = 1'b0;
      temp_hi_bias = 12'h888;
      temp_lo_bias = 12'h000;
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      repeat (2) @(negedge core_clk);
      t_defaults;
      t_modes;
      t_pairs;
      t_conv;
      t_temp_word;
      wrap_up;
   end
   initial begin
      #500000;
      mismatches++;
      wrap_up;
   end
endmodule
